// ==== rtl/odm_regs.svh ====
// Purpose: Offsets, field positions, reset values and fixed values for
//          the debug mailbox, identification and override block.
// Assumes: Included by the block's design file and testbench.
// Notes:   Definitions only.
`ifndef ODM_REGS_SVH
`define ODM_REGS_SVH

// Register indexes on the CPU and debugger access ports
`define ODM_IDX_W            3
`define ODM_IDX_ID           3'h0
`define ODM_IDX_CAP          3'h1
`define ODM_IDX_C2T          3'h2
`define ODM_IDX_T2C          3'h3
`define ODM_IDX_STAT         3'h4
`define ODM_IDX_MASK         3'h5

// Override mask keep bits
`define ODM_MASK_W           4
`define ODM_MASK_FOLD        0
`define ODM_MASK_RSTK        1
`define ODM_MASK_IBP         2
`define ODM_MASK_IEX         3
`define ODM_MASK_RST         4'h0

// Mailbox status bits
`define ODM_STAT_CPU_DATA_PENDING        0
`define ODM_STAT_TOOL_DATA_PENDING        1
`define ODM_MBOX_RST         32'h0000_0000

// Status word flags of the debug status message
`define ODM_ST_OCD           0
`define ODM_ST_LP            5
`define ODM_TCODE_W          6
`define ODM_TCODE_DEBUG_STATUS_MESSAGE       6'h00

// Capability word, static
`define ODM_CAP_VALUE        {3'h0, 1'h0, 3'h0, 1'h0, 1'h0, 1'h0, 1'h0, \
                              4'h6, 1'h1, 4'h2, 4'h6, 4'h0, 4'h0}

// Message queue depth
`define ODM_FIFO_DEPTH       4
`endif

// ==== rtl/odm_pkg.sv ====
// Purpose: Types shared by the debug mailbox block.
// Assumes: Constants come from odm_regs.svh.
// Notes:   Types only.
package odm_pkg;
  // Source of the message offered to the queue this cycle
  typedef enum logic [1:0] {
    MK_NONE,
    MK_DBG,
    MK_LP
  } odm_msg_kind_type;
endpackage : odm_pkg

// ==== rtl/odm_mailbox.sv ====
// Purpose: Debug mailbox, identification and capability words, CPU
//          optimization override mask and debug status messages.
// Assumes: CPU and debugger ports are on CORE_CLK, already synchronised.
// Notes:   Message queue back-pressure delays a message; a mode change undone while stalled is not reported.
`timescale 1ns/1ps
`include "odm_regs.svh"

// Small FIFO, width and depth set by parameters
module odm_fifo #(
  parameter int W = 38,
  parameter int D = 4
) (
  // Clock and control
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;
  // Full and empty from the word count
  assign in_ready  = (32'(cnt_q) < D); // Full at exactly D words
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;
  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  // Pointers wrap at the depth
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (32'(wr_q) == D - 1) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (32'(rd_q) == D - 1) ? '0 : rd_q + 1'b1;
      end
    end
  end
  // Occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : odm_fifo

module odm_mailbox
  import odm_pkg::*;
#(
  parameter logic [3:0]  REVISION = 4'h0,    // arbitrary value
  parameter logic [15:0] PRODUCT  = 16'h0001, // arbitrary value
  parameter logic [10:0] MAKER    = 11'h2a5   // arbitrary value
) (
  // Clock, reset, enable
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic        CLK_EN,
  // Core and debug unit state
  input  wire logic        OCD_ENABLE,
  input  wire logic        PROG_TRACE_EN,
  input  wire logic        DATA_BP_EN,
  input  wire logic        TRACE_OVERRUN_STALL,
  input  wire logic        TRACE_PORT_EN,
  input  wire logic        DEBUG_MODE,
  input  wire logic        OCD_MODE,
  input  wire logic        LOW_POWER,
  input  wire logic [31:0] ENTRY_CAUSE,
  // Optimization controls to the core
  output logic             FOLD_DISABLE,
  output logic             RETSTACK_DISABLE,
  output logic             PRECISE_BP,
  output logic             PRECISE_EXEC,
  // CPU debug register port
  input  wire logic        CPU_WR,
  input  wire logic        CPU_RD,
  input  wire logic [2:0]  CPU_ADDR,
  input  wire logic [31:0] CPU_WDATA,
  output logic [31:0]      CPU_RDATA,
  output logic             CPU_RVALID,
  // Debugger register port
  input  wire logic        TOOL_WR,
  input  wire logic        TOOL_RD,
  input  wire logic [2:0]  TOOL_ADDR,
  input  wire logic [31:0] TOOL_WDATA,
  output logic [31:0]      TOOL_RDATA,
  output logic             TOOL_RVALID,
  // Debug status message stream
  output logic             MSG_VALID,
  input  wire logic        MSG_READY,
  output logic [31:0]      MSG_STATUS,
  output logic [5:0]       MSG_TCODE
);
  localparam int MSG_W = 32 + `ODM_TCODE_W;
  logic [`ODM_MASK_W-1:0] mask_q;
  logic [31:0]            c2t_q;
  logic [31:0]            t2c_q;
  logic                   cpu_data_pending_q;
  logic                   tool_data_pending_q;
  logic                   dbg_rep_q;
  logic                   lp_rep_q;
  logic [31:0]            stat_word;
  logic [31:0]            id_word;
  logic                   ocd_hold;
  logic                   cpu_wr_c2t;
  logic                   tool_wr_c2t;
  logic                   tool_wr_t2c;
  logic                   cpu_wr_t2c;
  logic                   cpu_rd_t2c;
  logic                   tool_rd_c2t;
  logic                   cpu_wr_st;
  logic                   tool_wr_st;
  logic                   tool_wr_mask;
  odm_msg_kind_type       msg_kind;
  logic [31:0]            push_status;
  logic                   push_valid;
  logic                   push_ready;
  logic [MSG_W-1:0]       pop_data;
  // Identification word, bit zero fixed at one
  assign id_word   = {REVISION, PRODUCT, MAKER, 1'b1};
  // Reserved status bits forced to zero
  assign stat_word = {30'h0, tool_data_pending_q, cpu_data_pending_q};
  // Register read decode shared by both ports
  function automatic logic [31:0] rd_word(input logic [2:0] idx,
                                          input logic [31:0] idw,
                                          input logic [31:0] stw,
                                          input logic [31:0] c2t,
                                          input logic [31:0] t2c,
                                          input logic [3:0]  msk);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (idx)
      `ODM_IDX_ID:   r = idw;
      `ODM_IDX_CAP:  r = `ODM_CAP_VALUE;
      `ODM_IDX_C2T:  r = c2t;
      `ODM_IDX_T2C:  r = t2c;
      `ODM_IDX_STAT: r = stw;
      `ODM_IDX_MASK: r = {28'h0, msk};
      default:       r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd_word
  // Access strobes, all gated by the clock enable
  assign cpu_wr_c2t   = CLK_EN && CPU_WR && CPU_ADDR == `ODM_IDX_C2T;
  assign tool_wr_c2t  = CLK_EN && TOOL_WR && TOOL_ADDR == `ODM_IDX_C2T;
  assign tool_wr_t2c  = CLK_EN && TOOL_WR && TOOL_ADDR == `ODM_IDX_T2C;
  assign cpu_wr_t2c   = CLK_EN && CPU_WR && CPU_ADDR == `ODM_IDX_T2C;
  assign cpu_rd_t2c   = CLK_EN && CPU_RD && CPU_ADDR == `ODM_IDX_T2C;
  assign tool_rd_c2t  = CLK_EN && TOOL_RD && TOOL_ADDR == `ODM_IDX_C2T;
  assign cpu_wr_st    = CLK_EN && CPU_WR && CPU_ADDR == `ODM_IDX_STAT;
  assign tool_wr_st   = CLK_EN && TOOL_WR && TOOL_ADDR == `ODM_IDX_STAT;
  assign tool_wr_mask = CLK_EN && TOOL_WR && TOOL_ADDR == `ODM_IDX_MASK;
  // Reads while halted in OCD mode must not consume data
  assign ocd_hold     = DEBUG_MODE && OCD_MODE;
  // Override mask, written only by the debugger
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      mask_q <= `ODM_MASK_RST;
    end else if (tool_wr_mask) begin
      mask_q <= TOOL_WDATA[`ODM_MASK_W-1:0];
    end
  end
  // Optimization disables registered for timing to the core pipeline
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      FOLD_DISABLE     <= 1'b0;
      RETSTACK_DISABLE <= 1'b0;
      PRECISE_BP       <= 1'b0;
      PRECISE_EXEC     <= 1'b0;
    end else if (CLK_EN) begin
      FOLD_DISABLE     <= OCD_ENABLE && !mask_q[`ODM_MASK_FOLD];
      RETSTACK_DISABLE <= PROG_TRACE_EN && !mask_q[`ODM_MASK_RSTK];
      PRECISE_BP       <= OCD_ENABLE && !mask_q[`ODM_MASK_IBP];
      PRECISE_EXEC     <= (DATA_BP_EN || TRACE_OVERRUN_STALL)
                          && !mask_q[`ODM_MASK_IEX];
    end
  end
  // Mailbox data words; either side may write either word
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      c2t_q <= `ODM_MBOX_RST;
      t2c_q <= `ODM_MBOX_RST;
    end else begin
      if (cpu_wr_c2t) begin
        c2t_q <= CPU_WDATA;
      end else if (tool_wr_c2t) begin
        c2t_q <= TOOL_WDATA;
      end
      if (tool_wr_t2c) begin
        t2c_q <= TOOL_WDATA;
      end else if (cpu_wr_t2c) begin
        t2c_q <= CPU_WDATA;
      end
    end
  end
  // CPU-pending flag: a new write beats a same-cycle clear
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cpu_data_pending_q <= 1'b0;
    end else if (cpu_wr_c2t || tool_wr_c2t) begin
      cpu_data_pending_q <= 1'b1;
    end else if (tool_rd_c2t && !ocd_hold) begin
      cpu_data_pending_q <= 1'b0;
    end else if (cpu_wr_st) begin
      cpu_data_pending_q <= CPU_WDATA[`ODM_STAT_CPU_DATA_PENDING];
    end else if (tool_wr_st) begin
      cpu_data_pending_q <= TOOL_WDATA[`ODM_STAT_CPU_DATA_PENDING];
    end
  end
  // Tool-pending flag, same priority scheme
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      tool_data_pending_q <= 1'b0;
    end else if (tool_wr_t2c || cpu_wr_t2c) begin
      tool_data_pending_q <= 1'b1;
    end else if (cpu_rd_t2c && !ocd_hold) begin
      tool_data_pending_q <= 1'b0;
    end else if (cpu_wr_st) begin
      tool_data_pending_q <= CPU_WDATA[`ODM_STAT_TOOL_DATA_PENDING];
    end else if (tool_wr_st) begin
      tool_data_pending_q <= TOOL_WDATA[`ODM_STAT_TOOL_DATA_PENDING];
    end
  end
  // Read data registered, valid one cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      CPU_RDATA   <= 32'h0000_0000;
      CPU_RVALID  <= 1'b0;
      TOOL_RDATA  <= 32'h0000_0000;
      TOOL_RVALID <= 1'b0;
    end else if (CLK_EN) begin
      CPU_RVALID  <= CPU_RD;
      TOOL_RVALID <= TOOL_RD;
      if (CPU_RD) begin
        CPU_RDATA <= rd_word(CPU_ADDR, id_word, stat_word, c2t_q,
                             t2c_q, mask_q);
      end
      if (TOOL_RD) begin
        TOOL_RDATA <= rd_word(TOOL_ADDR, id_word, stat_word, c2t_q,
                              t2c_q, mask_q);
      end
    end
  end
  // Pick a pending mode change; debug mode changes go first
  always_comb begin
    msg_kind    = MK_NONE;
    push_status = 32'h0000_0000;
    if (DEBUG_MODE != dbg_rep_q) begin
      msg_kind = MK_DBG;
      if (DEBUG_MODE) begin
        push_status = ENTRY_CAUSE;
        push_status[`ODM_ST_OCD] = OCD_MODE;
      end
    end else if (LOW_POWER != lp_rep_q) begin
      msg_kind = MK_LP;
      if (LOW_POWER) begin
        push_status[`ODM_ST_LP] = 1'b1;
      end
    end
    // Exits leave push_status at zero
  end
  assign push_valid = TRACE_PORT_EN && msg_kind != MK_NONE;
  // With the trace port enabled, reported state advances only once the queue takes the message,
  // so a full queue stalls reporting; only a mode change undone while stalled goes unreported
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      dbg_rep_q <= 1'b0;
      lp_rep_q  <= 1'b0;
    end else if (CLK_EN) begin
      if (!TRACE_PORT_EN) begin
        dbg_rep_q <= DEBUG_MODE;
        lp_rep_q  <= LOW_POWER;
      end else if (push_ready && msg_kind == MK_DBG) begin
        dbg_rep_q <= DEBUG_MODE;
      end else if (push_ready && msg_kind == MK_LP) begin
        lp_rep_q <= LOW_POWER;
      end
    end
  end
  // Message queue toward the trace port packetizer
  odm_fifo #(
    .W (MSG_W),
    .D (`ODM_FIFO_DEPTH)
  ) u_msg_fifo (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .ce        (CLK_EN),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   ({push_status, `ODM_TCODE_DEBUG_STATUS_MESSAGE}),
    .out_valid (MSG_VALID),
    .out_ready (MSG_READY),
    .out_data  (pop_data)
  );

  assign MSG_STATUS = pop_data[MSG_W-1:`ODM_TCODE_W];
  assign MSG_TCODE  = pop_data[`ODM_TCODE_W-1:0];

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  fold_off_a: assert property (CLK_EN && OCD_ENABLE
      && !mask_q[`ODM_MASK_FOLD] |=> FOLD_DISABLE)
    else $error("fold not disabled with debug on");
  rstk_off_a: assert property (CLK_EN && PROG_TRACE_EN
      && !mask_q[`ODM_MASK_RSTK] |=> RETSTACK_DISABLE)
    else $error("return stack not disabled in trace");
  exec_keep_a: assert property (CLK_EN && mask_q[`ODM_MASK_IEX]
      |=> !PRECISE_EXEC)
    else $error("precise execution despite keep bit");
  bp_prec_a: assert property (CLK_EN && OCD_ENABLE
      && !mask_q[`ODM_MASK_IBP] |=> PRECISE_BP)
    else $error("breakpoints not precise");
  exit_zero_a: assert property (push_valid && msg_kind == MK_DBG
      && !DEBUG_MODE |-> push_status == 32'h0000_0000)
    else $error("exit message status not zero");
  lp_only_a: assert property (push_valid && msg_kind == MK_LP
      && LOW_POWER |-> push_status == (32'h1 << `ODM_ST_LP))
    else $error("low power message status wrong");
  code_zero_a: assert property (MSG_VALID
      |-> MSG_TCODE == `ODM_TCODE_DEBUG_STATUS_MESSAGE)
    else $error("message transfer code not zero");
  id_one_a: assert property (CLK_EN && CPU_RD
      && CPU_ADDR == `ODM_IDX_ID |=> CPU_RVALID && CPU_RDATA[0])
    else $error("id bit zero not one");
  cpu_data_pending_set_a: assert property (cpu_wr_c2t |=> cpu_data_pending_q ##0
      stat_word[`ODM_STAT_CPU_DATA_PENDING])
    else $error("cpu pending not set");
  tool_data_pending_clr_a: assert property (cpu_rd_t2c && !ocd_hold
      && !tool_wr_t2c && !cpu_wr_t2c |=> !tool_data_pending_q)
    else $error("tool pending not cleared by cpu read");
  ocd_keep_a: assert property (ocd_hold && cpu_data_pending_q
      && !cpu_wr_st && !tool_wr_st |=> cpu_data_pending_q)
    else $error("pending flag lost in ocd mode");
  stat_resv_a: assert property (CLK_EN && TOOL_RD
      && TOOL_ADDR == `ODM_IDX_STAT |=> TOOL_RDATA[31:2] == 30'h0)
    else $error("reserved status bits not zero");
  mask_hold_a: assert property (!tool_wr_mask |=> $stable(mask_q))
    else $error("override mask changed without write");

  msg_push_c: cover property (push_valid && push_ready);
  fifo_full_c: cover property (push_valid && !push_ready);
  tool_rd_c: cover property (tool_rd_c2t && cpu_data_pending_q ##1 !cpu_data_pending_q);
endmodule : odm_mailbox

// ==== testbench/odm_tool_model.sv ====
// Purpose: Debugger-side model: tool register port and message sink.
// Assumes: Requests change just after CORE_CLK rising edges.
// Notes:   The sink can stall to back-pressure the message queue.
`timescale 1ns/1ps
module odm_tool_model (
  // Clock
  input  wire logic        clk,
  // Tool register port
  output logic             tool_wr,
  output logic             tool_rd,
  output logic [2:0]       tool_addr,
  output logic [31:0]      tool_wdata,
  input  wire logic [31:0] tool_rdata,
  input  wire logic        tool_rvalid,
  // Message sink
  input  wire logic        msg_valid,
  output logic             msg_ready,
  input  wire logic [31:0] msg_status,
  input  wire logic [5:0]  msg_tcode
);
  logic        stall;
  logic [37:0] got[$];

  // Quiet port at time zero
  initial begin
    stall = 1'b0;
    tool_wr = 1'b0;
    tool_rd = 1'b0;
    tool_addr = 3'h7;
    tool_wdata = 32'h0;
    msg_ready = 1'b0;
  end

  // Ready follows the stall request one edge later
  always @(posedge clk) begin
    msg_ready <= !stall;
  end

  // Keep every accepted message word
  always @(posedge clk) begin
    if (msg_valid === 1'b1 && msg_ready) begin
      got.push_back({msg_status, msg_tcode});
    end
  end

  // One-word write; released lines show inverted data
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    tool_wr <= 1'b1;
    tool_addr <= a;
    tool_wdata <= d;
    @(posedge clk);
    tool_wr <= 1'b0;
    tool_addr <= ~a;
    tool_wdata <= ~d;
  endtask : wr

  // One-word read; data taken in the answer cycle
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    tool_rd <= 1'b1;
    tool_addr <= a;
    @(posedge clk);
    tool_rd <= 1'b0;
    tool_addr <= ~a;
    #1;
    d = tool_rvalid ? tool_rdata : 'x;
  endtask : rd
endmodule : odm_tool_model

// ==== testbench/odm_mailbox_tb.sv ====
// Purpose: Self-checking bench for the debug mailbox block.
// Assumes: Debugger side is odm_tool_model; clock enable held high.
// Notes:   One task per scenario; summarize prints the verdict.
`timescale 1ns/1ps
`include "odm_regs.svh"
module odm_mailbox_tb;
  localparam logic [3:0]  REV = 4'h3;     // arbitrary value
  localparam logic [15:0] PRD = 16'h0a5c; // arbitrary value
  localparam logic [10:0] MKR = 11'h155;  // arbitrary value
  logic        clk, rst, ocd_en, trc_en, dbp_en, ovs_en, port_en;
  logic        dbg_mode, ocd_mode, low_pwr;
  logic [31:0] cause;
  logic        fold_dis, rstk_dis, prec_bp, prec_ex;
  logic        cpu_wr, cpu_rd, cpu_rvalid, tool_wr, tool_rd, tool_rvalid;
  logic [2:0]  cpu_addr, tool_addr;
  logic [31:0] cpu_wdata, cpu_rdata, tool_wdata, tool_rdata;
  logic        msg_valid, msg_ready;
  logic [31:0] msg_status;
  logic [5:0]  msg_tcode;
  logic [37:0] exp_q[$];
  int          n_mismatch, samples_checked;

  odm_mailbox #(.REVISION(REV), .PRODUCT(PRD), .MAKER(MKR))
    odm_mailbox_inst (
    .CORE_CLK(clk), .RESET(rst), .CLK_EN(1'b1),
    .OCD_ENABLE(ocd_en), .PROG_TRACE_EN(trc_en), .DATA_BP_EN(dbp_en),
    .TRACE_OVERRUN_STALL(ovs_en), .TRACE_PORT_EN(port_en),
    .DEBUG_MODE(dbg_mode), .OCD_MODE(ocd_mode), .LOW_POWER(low_pwr),
    .ENTRY_CAUSE(cause), .FOLD_DISABLE(fold_dis),
    .RETSTACK_DISABLE(rstk_dis), .PRECISE_BP(prec_bp),
    .PRECISE_EXEC(prec_ex), .CPU_WR(cpu_wr), .CPU_RD(cpu_rd),
    .CPU_ADDR(cpu_addr), .CPU_WDATA(cpu_wdata), .CPU_RDATA(cpu_rdata),
    .CPU_RVALID(cpu_rvalid), .TOOL_WR(tool_wr), .TOOL_RD(tool_rd),
    .TOOL_ADDR(tool_addr), .TOOL_WDATA(tool_wdata),
    .TOOL_RDATA(tool_rdata), .TOOL_RVALID(tool_rvalid),
    .MSG_VALID(msg_valid), .MSG_READY(msg_ready),
    .MSG_STATUS(msg_status), .MSG_TCODE(msg_tcode));

  odm_tool_model odm_tool_model_inst (
    .clk(clk), .tool_wr(tool_wr), .tool_rd(tool_rd),
    .tool_addr(tool_addr), .tool_wdata(tool_wdata),
    .tool_rdata(tool_rdata), .tool_rvalid(tool_rvalid),
    .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_status(msg_status), .msg_tcode(msg_tcode));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare and count; x never matches
  task automatic chk(input string w, input logic [37:0] g,
                     input logic [37:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  // CPU port write, released lines inverted
  task automatic cpu_w(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_wr <= 1'b0;
    cpu_addr <= ~a;
    cpu_wdata <= ~d;
  endtask : cpu_w

  // CPU port read, data taken in the answer cycle
  task automatic cpu_r(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge clk);
    cpu_rd <= 1'b0;
    cpu_addr <= ~a;
    #1;
    d = cpu_rvalid ? cpu_rdata : 'x;
  endtask : cpu_r

  // Fixed words; writes to them and to a hole are dropped
  task automatic t_ident();
    logic [31:0] d;
    odm_tool_model_inst.wr(`ODM_IDX_ID, 32'h0);
    odm_tool_model_inst.wr(`ODM_IDX_CAP, 32'hffff_ffff);
    cpu_w(3'h6, 32'hffff_ffff);
    odm_tool_model_inst.rd(`ODM_IDX_ID, d);
    chk("id tool", d, {REV, PRD, MKR, 1'b1});
    cpu_r(`ODM_IDX_ID, d);
    chk("id cpu", d, {REV, PRD, MKR, 1'b1});
    odm_tool_model_inst.rd(`ODM_IDX_CAP, d);
    chk("cap", d, {11'h0, 4'h6, 1'b1, 4'h2, 4'h6, 8'h0});
    cpu_r(3'h6, d);
    chk("hole", d, 32'h0);
    cpu_r(`ODM_IDX_C2T, d);
    chk("c2t reset", d, 32'h0);
    cpu_r(`ODM_IDX_T2C, d);
    chk("t2c reset", d, 32'h0);
  endtask : t_ident

  // Both mailboxes, then reads in debug mode that keep flags
  task automatic t_mbox();
    logic [31:0] d;
    cpu_r(`ODM_IDX_STAT, d);
    chk("stat idle", d, 32'h0);
    cpu_w(`ODM_IDX_C2T, 32'h1234_5678);
    odm_tool_model_inst.rd(`ODM_IDX_STAT, d);
    chk("cpu_data_pending set", d, 32'h1);
    odm_tool_model_inst.rd(`ODM_IDX_C2T, d);
    chk("c2t data", d, 32'h1234_5678);
    cpu_r(`ODM_IDX_STAT, d);
    chk("cpu_data_pending clr", d, 32'h0);
    odm_tool_model_inst.wr(`ODM_IDX_T2C, 32'h9abc_def0);
    cpu_r(`ODM_IDX_STAT, d);
    chk("tool_data_pending set", d, 32'h2);
    cpu_r(`ODM_IDX_T2C, d);
    chk("t2c data", d, 32'h9abc_def0);
    odm_tool_model_inst.rd(`ODM_IDX_STAT, d);
    chk("tool_data_pending clr", d, 32'h0);
    @(posedge clk);
    dbg_mode <= 1'b1;
    ocd_mode <= 1'b1;
    cpu_w(`ODM_IDX_C2T, 32'h0f0f_0f0f);
    odm_tool_model_inst.wr(`ODM_IDX_T2C, 32'h5a5a_5a5a);
    odm_tool_model_inst.rd(`ODM_IDX_C2T, d);
    cpu_r(`ODM_IDX_T2C, d);
    cpu_r(`ODM_IDX_STAT, d);
    chk("flags kept", d, 32'h3);
    @(posedge clk);
    dbg_mode <= 1'b0;
    odm_tool_model_inst.rd(`ODM_IDX_C2T, d);
    cpu_r(`ODM_IDX_T2C, d);
    cpu_r(`ODM_IDX_STAT, d);
    chk("flags clr", d, 32'h0);
    cpu_w(`ODM_IDX_STAT, 32'hffff_ffff);
    odm_tool_model_inst.rd(`ODM_IDX_STAT, d);
    chk("stat wr", d, 32'h3);
    odm_tool_model_inst.wr(`ODM_IDX_STAT, 32'h0);
    cpu_r(`ODM_IDX_STAT, d);
    chk("stat clr", d, 32'h0);
  endtask : t_mbox

  // Every keep mask against every disable condition
  task automatic t_override();
    logic [31:0] d;
    logic [3:0]  x;
    for (int c = 0; c < 16; c++) begin
      for (int m = 0; m < 16; m++) begin
        @(posedge clk);
        ocd_en <= c[0];
        trc_en <= c[1];
        dbp_en <= c[2];
        ovs_en <= c[3];
        odm_tool_model_inst.wr(`ODM_IDX_MASK, 32'(m));
        cpu_w(`ODM_IDX_MASK, ~32'(m));
        odm_tool_model_inst.rd(`ODM_IDX_MASK, d);
        chk("mask", d, 32'(m));
        x = {(c[2] | c[3]) & !m[3], c[0] & !m[2], c[1] & !m[1],
             c[0] & !m[0]};
        chk("opt ctl", {prec_ex, prec_bp, rstk_dis, fold_dis}, x);
      end
    end
  endtask : t_override

  // Change mode state, note the message it should raise
  task automatic step(input logic dm, input logic om, input logic lp,
                      input logic want, input logic [31:0] e);
    @(posedge clk);
    dbg_mode <= dm;
    ocd_mode <= om;
    low_pwr <= lp;
    if (want) begin
      exp_q.push_back({e, 6'h00});
    end
    repeat (4) @(posedge clk);
  endtask : step

  // Mode messages, muted port, then a full queue under stall
  task automatic t_msgs();
    logic [31:0] cz;
    cz = 32'h0000_0a41;
    @(posedge clk);
    port_en <= 1'b1;
    cause <= cz;
    step(1'b1, 1'b1, 1'b0, 1'b1, cz | 32'h1);
    step(1'b0, 1'b1, 1'b0, 1'b1, 32'h0);
    step(1'b1, 1'b0, 1'b0, 1'b1, cz & ~32'h1);
    step(1'b0, 1'b0, 1'b0, 1'b1, 32'h0);
    step(1'b0, 1'b0, 1'b1, 1'b1, 32'h20);
    step(1'b0, 1'b0, 1'b0, 1'b1, 32'h0);
    @(posedge clk);
    port_en <= 1'b0;
    step(1'b1, 1'b1, 1'b0, 1'b0, 32'h0);
    step(1'b0, 1'b1, 1'b0, 1'b0, 32'h0);
    @(posedge clk);
    port_en <= 1'b1;
    odm_tool_model_inst.stall <= 1'b1;
    step(1'b0, 1'b0, 1'b1, 1'b1, 32'h20);
    step(1'b0, 1'b0, 1'b0, 1'b1, 32'h0);
    step(1'b1, 1'b1, 1'b0, 1'b1, cz | 32'h1);
    step(1'b0, 1'b1, 1'b0, 1'b1, 32'h0);
    step(1'b0, 1'b0, 1'b1, 1'b1, 32'h20);
    #1;
    chk("msg held", 38'(msg_valid), 38'h1);
    chk("msg early", 38'(odm_tool_model_inst.got.size()), 38'd6);
    @(posedge clk);
    odm_tool_model_inst.stall <= 1'b0;
    repeat (16) @(posedge clk);
    #1;
    chk("drained", 38'(msg_valid), 38'h0);
    chk("msg count", 38'(odm_tool_model_inst.got.size()),
        38'(exp_q.size()));
    foreach (exp_q[i]) begin
      chk("msg word", odm_tool_model_inst.got[i], exp_q[i]);
    end
  endtask : t_msgs

  // Verdict and end of run
  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Reset, then the scenarios in turn
  initial begin
    {rst, ocd_en, trc_en, dbp_en, ovs_en, port_en} = 6'h20; // Port off
    {dbg_mode, ocd_mode, low_pwr, cpu_wr, cpu_rd} = 5'h0;
    {cause, cpu_addr, cpu_wdata} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_ident();
    t_mbox();
    t_override();
    t_msgs();
    summarize();
  end

  // Hang guard, the run needs about 2000 cycles
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule : odm_mailbox_tb
